// ===== design/eepsl_dev.sv
/*
  EEPROM end of the two-wire bus: address decode, acknowledge, 14-bit
  address counter, 64-byte page buffer, internal write cycle, write
  protect, immediate, selective and sequential reads.
  Assumes a free-running internal link clock much faster than the serial
  clock; bus pins, straps and write protect arrive asynchronously.
*/
// How it works
// R1: Power-on reset returns device to standby.
// R2: Sample on rising clock, drive after falling.
// R3: Master keeps data stable while clock high.
// R4: START precedes commands; otherwise ignore bus.
// R5: STOP completes every command.
// R6: Address 1010, three straps, then direction bit.
// R7: Acknowledge address, memory address, written data.
// R8: Send bytes while master keeps acknowledging.
// R9: Master ends read with NoACK then STOP.
// R10: Two bytes load 14-bit address counter.
// R11: Data fills page buffer; STOP commits it.
// R12: During write cycle stay released, ignore requests.
// R13: No slave-address acknowledge while write busy.
// R14: Page fixed, offset wraps, later bytes overwrite.
// R15: Commit only latest sequence's loaded bytes.
// R16: Write protect high blocks every write.
// R17: Sample protect before first data byte.
// R18: Array starts erased, all ones.
// R19: Read address sends byte at counter.
// R20: Repeated start after address gives selective read.
// R21: Sequential read wraps at end of memory.
// R22: Write cycle lasts a parameter cycle count.
// R23: Counter points past the last byte accessed.
`timescale 1ns/1ps
module eepsl_dev
  import eepsl_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES, // Write cycle length in clocks
  parameter int AW       = MEM_AW       // Memory address width
) (
  input  wire logic link_clk,          // Internal link-side clock
  input  wire logic rst,               // Power-on reset, sync, high
  eepsl_if.slave    bus,               // Two-wire bus
  input  wire logic strap_select_bit0, // Address strap 0
  input  wire logic strap_select_bit1, // Address strap 1
  input  wire logic strap_select_bit2, // Address strap 2
  input  wire logic write_protect,     // High blocks all writes
  output logic      prog_busy          // Internal write cycle running
);

  localparam int PW = $clog2(PROG_CYC + 1);
  localparam int OW = OFS_W;

  typedef enum logic [2:0] {
    S_IDLE,
    S_DEV,
    S_HI,
    S_LO,
    S_WR,
    S_RD,
    S_SKIP
  } eepsl_dst_type;

  typedef struct packed {
    logic                  scl_m;
    logic                  scl_s;
    logic                  scl_p;
    logic                  sda_m;
    logic                  sda_s;
    logic                  sda_p;
    logic [2:0]            strap_m;
    logic [2:0]            strap_s;
    logic                  wp_m;
    logic                  wp_s;
    eepsl_dst_type         st;
    logic [3:0]            bitn;
    logic [7:0]            sh;
    logic [AW-1:0]         addr;
    logic                  oe;
    logic                  wp;
    logic                  mack;
    logic                  busy;
    logic [PW-1:0]         pcnt;
    logic [PAGE_BYTES-1:0] loaded;
    logic [AW-OW-1:0]      page;
  } eepsl_dstate_type;

  eepsl_dstate_type r_r;
  eepsl_dstate_type r_nxt;

  // Erased delivery state; the array has no reset of its own
  logic [7:0] mem [0:(1<<AW)-1] = '{default: ERASED_BYTE}; // R18
  logic [7:0] pbuf [0:PAGE_BYTES-1];
  logic       mem_we;
  logic       pb_we;
  logic [7:0] rd_byte;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       addr_hit;

  assign rd_byte   = mem[r_r.addr];
  assign scl_rise  = r_r.scl_s & ~r_r.scl_p; // R2
  assign scl_fall  = ~r_r.scl_s & r_r.scl_p;
  assign bus_start = r_r.scl_s & r_r.scl_p & r_r.sda_p & ~r_r.sda_s; // R4
  assign bus_stop  = r_r.scl_s & r_r.scl_p & ~r_r.sda_p & r_r.sda_s; // R5
  assign addr_hit  = (r_r.sh[7:4] == DEV_TYPE)
                   && (r_r.sh[3:1] == r_r.strap_s); // R6

  always_comb begin
    r_nxt  = r_r;
    mem_we = 1'b0;
    pb_we  = 1'b0;
    // Pins are asynchronous: two flops before anything reads them
    r_nxt.scl_m   = bus.scl;
    r_nxt.scl_s   = r_r.scl_m;
    r_nxt.scl_p   = r_r.scl_s;
    r_nxt.sda_m   = bus.sda;
    r_nxt.sda_s   = r_r.sda_m;
    r_nxt.sda_p   = r_r.sda_s;
    r_nxt.strap_m = {strap_select_bit2, strap_select_bit1,
                     strap_select_bit0};
    r_nxt.strap_s = r_r.strap_m;
    r_nxt.wp_m    = write_protect;
    r_nxt.wp_s    = r_r.wp_m;

    // Commit walks the page one byte per clock, then waits out the time
    if (r_r.busy) begin
      if (r_r.pcnt < PW'(PAGE_BYTES)) begin
        mem_we = r_r.loaded[r_r.pcnt[OW-1:0]]; // R15
      end
      r_nxt.pcnt = r_r.pcnt + PW'(1);
      if (r_r.pcnt == PW'(PROG_CYC - 1)) begin
        r_nxt.busy = 1'b0; // R22
      end
    end

    if (bus_start) begin
      r_nxt.st   = S_DEV; // R4
      r_nxt.bitn = 4'h0;
      r_nxt.oe   = 1'b0;
    end else if (bus_stop) begin
      if (r_r.st == S_WR && |r_r.loaded && !r_r.busy) begin
        r_nxt.busy = 1'b1; // R11
        r_nxt.pcnt = '0; // R22
      end
      r_nxt.st = S_IDLE; // R5
      r_nxt.oe = 1'b0;
    end else if (r_r.st != S_IDLE && r_r.st != S_SKIP) begin
      if (scl_rise) begin
        if (r_r.bitn < 4'(ACK_BIT) && r_r.st != S_RD) begin
          r_nxt.sh = {r_r.sh[6:0], r_r.sda_s}; // R2
        end
        if (r_r.bitn == 4'(ACK_BIT)) begin
          r_nxt.mack = ~r_r.sda_s; // R8
        end
        if (r_r.bitn < 4'(END_BIT)) begin
          r_nxt.bitn = r_r.bitn + 4'h1;
        end
      end else if (scl_fall) begin
        if (r_r.bitn == 4'(ACK_BIT)) begin
          // Acknowledge slot opens; a read byte releases the line here
          r_nxt.oe = 1'b0; // R8
          case (r_r.st)
            S_DEV: begin
              if (addr_hit && !r_r.busy) begin
                r_nxt.oe = 1'b1; // R7
              end else begin
                r_nxt.st = S_SKIP; // R13
              end
            end
            S_HI: begin
              r_nxt.addr[AW-1:8] = r_r.sh[AW-9:0]; // R10
              r_nxt.oe = 1'b1; // R7
            end
            S_LO: begin
              r_nxt.addr[7:0] = r_r.sh; // R10
              r_nxt.oe = 1'b1; // R7
            end
            S_WR: begin
              if (r_r.wp) begin
                r_nxt.st     = S_SKIP; // R17
                r_nxt.loaded = '0; // R16
              end else begin
                r_nxt.oe = 1'b1; // R7
                pb_we    = 1'b1; // R11
                r_nxt.loaded[r_r.addr[OW-1:0]] = 1'b1; // R14
                r_nxt.addr = {r_r.addr[AW-1:OW],
                              r_r.addr[OW-1:0] + OW'(1)}; // R14
              end
            end
            default: begin
            end
          endcase
        end else if (r_r.bitn == 4'(END_BIT)) begin
          r_nxt.bitn = 4'h0;
          r_nxt.oe   = 1'b0;
          case (r_r.st)
            S_DEV: begin
              if (r_r.sh[0]) begin
                r_nxt.st   = S_RD; // R19
                r_nxt.oe   = ~rd_byte[7]; // R20
                r_nxt.sh   = {rd_byte[6:0], 1'b0};
                r_nxt.addr = r_r.addr + AW'(1); // R23
              end else begin
                r_nxt.st = S_HI; // R10
              end
            end
            S_HI: begin
              r_nxt.st = S_LO;
            end
            S_LO: begin
              // Protect level is taken on the last fall before data
              r_nxt.st     = S_WR;
              r_nxt.loaded = '0; // R15
              r_nxt.page   = r_r.addr[AW-1:OW]; // R14
              r_nxt.wp     = r_r.wp_s; // R17
            end
            S_RD: begin
              if (r_r.mack) begin
                r_nxt.oe   = ~rd_byte[7]; // R8
                r_nxt.sh   = {rd_byte[6:0], 1'b0};
                r_nxt.addr = r_r.addr + AW'(1); // R21
              end else begin
                r_nxt.st = S_SKIP; // R9
              end
            end
            default: begin
            end
          endcase
        end else if (r_r.st == S_RD && r_r.bitn != 4'h0) begin
          r_nxt.oe = ~r_r.sh[7]; // R2
          r_nxt.sh = {r_r.sh[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst) begin
      r_r <= '0; // R1
    end else begin
      r_r <= r_nxt;
    end
  end

  always_ff @(posedge link_clk) begin
    if (pb_we) begin
      pbuf[r_r.addr[OW-1:0]] <= r_r.sh; // R14
    end
    if (mem_we) begin
      mem[{r_r.page, r_r.pcnt[OW-1:0]}] <= pbuf[r_r.pcnt[OW-1:0]]; // R15
    end
  end

  // Busy cannot start a new acknowledge, so the line stays released
  assign bus.s_sda_oe = r_r.oe; // R12
  assign bus.s_sda_o  = 1'b0;
  assign prog_busy    = r_r.busy;

endmodule

// ===== design/eepsl_pkg.sv
/*
  Shared constants and types for the two-wire serial EEPROM slave and
  the bus master that drives it.
  Assumes both ends import this package whole.
*/
package eepsl_pkg;

  // Device-type pattern in the upper nibble of the slave address
  localparam logic [3:0] DEV_TYPE     = 4'hA;
  localparam int         MEM_AW       = 14;
  localparam int         OFS_W        = 6;
  localparam int         PAGE_BYTES   = 64;
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;
  localparam int         ACK_BIT      = 8;
  localparam int         END_BIT      = 9;

  // internal_program_time, longest figure, counted on the link clock
  localparam longint     PROG_TIME_NS   = 5000000;
  localparam longint     LINK_PERIOD_PS = 12000;
  localparam int         PROG_CYCLES    =
    int'(PROG_TIME_NS * 1000 / LINK_PERIOD_PS);

  // Master side: 25 MHz clock, serial clock made by a quarter divider
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         SCL_PERIOD_NS = 2500;
  localparam int         QTR_CYCLES    =
    SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    OP_START,
    OP_STOP,
    OP_WRITE,
    OP_READ
  } eepsl_op_type;

endpackage

// ===== design/eepsl_if.sv
/*
  Two-wire bus between the master end and the EEPROM end.
  Assumes the master alone drives the serial clock; the data line is
  open-drain and resolved here as a wired AND of both drivers.
*/
`timescale 1ns/1ps
interface eepsl_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic sda;

  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport slave  (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

// ===== design/eepsl_host.sv
/*
  Master end of the two-wire bus: makes the serial clock from its own
  clock by a quarter-period divider and runs byte-level commands.
  Assumes the user issues START before any byte and ends with STOP.
*/
`timescale 1ns/1ps
module eepsl_host
  import eepsl_pkg::*;
#(
  parameter int QTR = QTR_CYCLES // Clocks per quarter serial period
) (
  input  wire logic         clk,       // System clock, 25 MHz
  input  wire logic         rst,       // Sync reset, high
  eepsl_if.master           bus,       // Two-wire bus
  input  wire logic         cmd_valid, // Command offered
  output logic              cmd_ready, // Command taken when both high
  input  wire eepsl_op_type cmd_op,    // START, STOP, WRITE, READ
  input  wire logic [7:0]   cmd_data,  // Byte to write
  input  wire logic         cmd_mack,  // Read: acknowledge the byte
  output logic              rsp_valid, // One-cycle byte result
  output logic [7:0]        rsp_data,  // Byte received
  output logic              rsp_nack   // Ninth bit was high
);

  localparam int TW = $clog2(QTR + 1);

  typedef enum logic [1:0] {
    H_IDLE,
    H_START,
    H_STOP,
    H_BIT
  } eepsl_hst_type;

  typedef struct packed {
    eepsl_hst_type st;
    logic [1:0]    q;
    logic [TW-1:0] tick;
    logic [3:0]    bitn;
    logic [8:0]    tx;
    logic [8:0]    rx;
    logic          scl;
    logic          oe;
    logic          sda_m;
    logic          sda_s;
    logic          rsp_v;
    logic [7:0]    rsp_d;
    logic          rsp_n;
  } eepsl_hstate_type;

  eepsl_hstate_type r_r;
  eepsl_hstate_type r_nxt;

  always_comb begin
    r_nxt       = r_r;
    r_nxt.sda_m = bus.sda;
    r_nxt.sda_s = r_r.sda_m;
    r_nxt.rsp_v = 1'b0;
    if (r_r.st == H_IDLE) begin
      if (cmd_valid) begin
        r_nxt.q    = 2'h0;
        r_nxt.tick = '0;
        r_nxt.bitn = 4'h0;
        r_nxt.scl  = 1'b0;
        case (cmd_op)
          OP_START: begin
            r_nxt.st = H_START;
            r_nxt.oe = 1'b0;
          end
          OP_STOP: begin
            r_nxt.st = H_STOP;
            r_nxt.oe = 1'b1;
          end
          OP_WRITE: begin
            r_nxt.st = H_BIT;
            r_nxt.tx = {cmd_data, 1'b1};
            r_nxt.oe = ~cmd_data[7]; // R3
          end
          default: begin
            r_nxt.st = H_BIT;
            r_nxt.tx = {8'hFF, ~cmd_mack}; // R9
            r_nxt.oe = 1'b0;
          end
        endcase
      end
    end else if (r_r.tick == TW'(QTR - 1)) begin
      r_nxt.tick = '0;
      r_nxt.q    = r_r.q + 2'h1;
      case (r_r.q)
        2'h0: r_nxt.scl = 1'b1;
        2'h1: begin
          // START and STOP move data only here, with the clock held high
          if (r_r.st == H_START) begin
            r_nxt.oe = 1'b1; // R4
          end else if (r_r.st == H_STOP) begin
            r_nxt.oe = 1'b0; // R5
          end
        end
        2'h2: begin
          if (r_r.st == H_BIT) begin
            r_nxt.rx  = {r_r.rx[7:0], r_r.sda_s};
            r_nxt.scl = 1'b0;
          end else if (r_r.st == H_START) begin
            r_nxt.scl = 1'b0;
          end
        end
        default: begin
          if (r_r.st == H_BIT && r_r.bitn != 4'(ACK_BIT)) begin
            r_nxt.bitn = r_r.bitn + 4'h1;
            r_nxt.tx   = {r_r.tx[7:0], 1'b1};
            r_nxt.oe   = ~r_r.tx[7]; // R3
          end else begin
            r_nxt.st = H_IDLE;
            if (r_r.st == H_BIT) begin
              r_nxt.rsp_v = 1'b1;
              r_nxt.rsp_d = r_r.rx[8:1];
              r_nxt.rsp_n = r_r.rx[0];
            end
          end
        end
      endcase
    end else begin
      r_nxt.tick = r_r.tick + TW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_r     <= '0;
      r_r.scl <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign cmd_ready    = (r_r.st == H_IDLE);
  assign rsp_valid    = r_r.rsp_v;
  assign rsp_data     = r_r.rsp_d;
  assign rsp_nack     = r_r.rsp_n;
  assign bus.scl      = r_r.scl;
  assign bus.m_sda_oe = r_r.oe;
  assign bus.m_sda_o  = 1'b0;

endmodule

// ===== dv/eepsl_asserts.sv
/*
  Concurrent checks on the two-wire bus, seen from the device clock.
  Assumes the serial clock is far slower than the device clock, so a
  raw pin edge is seen here before the device reacts to it.
*/
`timescale 1ns/1ps
module eepsl_asserts #(
  parameter int PROG_CYC = 1000 // Write cycle length in link clocks
) (
  input wire logic link_clk,  // Device clock
  input wire logic rst,       // Sync reset, high
  input wire logic scl,       // Serial clock
  input wire logic sda,       // Resolved data line
  input wire logic s_sda_oe,  // Device pulls data low
  input wire logic prog_busy  // Write cycle running
);
  logic       scl_q, sda_q, in_q, first_q, drove_q;
  logic [3:0] bit_q;
  int         busy_cnt;
  wire        rise  = scl && !scl_q;
  wire        start = scl && scl_q && sda_q && !sda;
  wire        stop  = scl && scl_q && !sda_q && sda;

  // Bit index within the byte, reset by every START
  always_ff @(posedge link_clk) begin
    if (rst) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      in_q     <= 1'b0;
      first_q  <= 1'b0;
      drove_q  <= 1'b0;
      bit_q    <= 4'h0;
      busy_cnt <= 0;
    end else begin
      scl_q    <= scl;
      sda_q    <= sda;
      busy_cnt <= prog_busy ? busy_cnt + 1 : 0;
      if (start) begin
        in_q    <= 1'b1;
        first_q <= 1'b1;
        drove_q <= 1'b0;
        bit_q   <= 4'h0;
      end else if (stop) begin
        in_q <= 1'b0;
      end else if (rise) begin
        bit_q   <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
        drove_q <= (bit_q != 4'h8) && (drove_q || s_sda_oe);
        if (bit_q == 4'h8) begin
          first_q <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (rst);

  chk_addr_listen: assert property (
    rise && first_q && bit_q < 4'h8 |-> !s_sda_oe)
    else $error("device drove the line during the slave address");
  chk_frame_only: assert property (!in_q |-> !s_sda_oe)
    else $error("device drove the line outside a frame");
  chk_busy_quiet: assert property (prog_busy |-> !s_sda_oe)
    else $error("device drove the line during the write cycle");
  chk_busy_no_ack: assert property (
    prog_busy && rise && bit_q == 4'h8 |-> sda)
    else $error("acknowledge seen during the write cycle");
  chk_oe_scl_low: assert property (scl && scl_q |-> $stable(s_sda_oe))
    else $error("device data changed while the clock was high");
  chk_read_release: assert property (
    rise && bit_q == 4'h8 && drove_q |-> !s_sda_oe)
    else $error("device held the line on the ninth read clock");
  chk_prog_len: assert property (
    $fell(prog_busy) |-> busy_cnt == PROG_CYC)
    else $error("write cycle length wrong");
  chk_commit_idle: assert property (
    $rose(prog_busy) |-> scl && sda && !in_q)
    else $error("write cycle began without a STOP");
endmodule

// ===== dv/tb_i2c_serial_eeprom_slave.sv
/*
  Bench joining the bus master end to the EEPROM end over the interface.
  Assumes short divider and write-cycle figures set below.
*/
`timescale 1ns/1ps
module tb_i2c_serial_eeprom_slave;
  import eepsl_pkg::*;
  localparam int QTR_T  = 4;
  localparam int PROG_T = 1000; // Long enough that the first poll meets busy
  logic         clk, link_clk, rst, cmd_valid, cmd_ready, cmd_mack, nk;
  logic         rsp_valid, rsp_nack, write_protect, prog_busy;
  logic [7:0]   cmd_data, rsp_data, rd;
  logic [2:0]   strap;
  eepsl_op_type cmd_op;
  int           error_cnt = 0, check_count = 0, busy_n = 0, i, b0;
  eepsl_if bus_if ();

  eepsl_host #(.QTR(QTR_T)) u_eepsl_host (.clk(clk), .rst(rst),
    .bus(bus_if.master), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_mack(cmd_mack),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  eepsl_dev #(.PROG_CYC(PROG_T), .AW(MEM_AW)) u_eepsl_dev (
    .link_clk(link_clk), .rst(rst), .bus(bus_if.slave),
    .strap_select_bit0(strap[0]), .strap_select_bit1(strap[1]),
    .strap_select_bit2(strap[2]), .write_protect(write_protect),
    .prog_busy(prog_busy));
  eepsl_asserts #(.PROG_CYC(PROG_T)) u_eepsl_asserts (.link_clk(link_clk),
    .rst(rst), .scl(bus_if.scl), .sda(bus_if.sda),
    .s_sda_oe(bus_if.s_sda_oe), .prog_busy(prog_busy));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge prog_busy) busy_n++;

  task automatic chk(input string what, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ready is sampled at the falling edge so the take edge is never raced
  task automatic do_cmd(input eepsl_op_type op, input logic [7:0] d,
                        input logic mk);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_data  <= d;
    cmd_mack  <= mk;
    do @(negedge clk); while (cmd_ready !== 1'b1 && ++n < 2000);
    if (n >= 2000) error_cnt++;
    @(posedge clk);
    cmd_valid <= 1'b0;
    if (op == OP_WRITE || op == OP_READ) begin
      do @(negedge clk); while (rsp_valid !== 1'b1 && ++n < 4000);
      if (rsp_valid !== 1'b1) error_cnt++;
      rd = rsp_data;
      nk = rsp_nack;
    end
  endtask

  task automatic wb(input logic [7:0] d, input logic en);
    do_cmd(OP_WRITE, d, 1'b0);
    chk("ack bit", {7'h00, nk}, {7'h00, en});
    chk("wire byte", rd, d);
  endtask
  task automatic sa(input logic rw, input logic en);
    do_cmd(OP_START, 8'h00, 1'b0);
    wb({DEV_TYPE, strap, rw}, en);
  endtask
  task automatic sel(input logic [7:0] hi, lo);
    sa(1'b0, 1'b0);
    wb(hi, 1'b0);
    wb(lo, 1'b0);
  endtask
  task automatic rb(input logic mk, input logic [7:0] exp);
    do_cmd(OP_READ, 8'h00, mk);
    chk("read byte", rd, exp);
  endtask
  task automatic poll;
    int k;
    k = 0;
    do begin
      do_cmd(OP_START, 8'h00, 1'b0);
      do_cmd(OP_WRITE, {DEV_TYPE, strap, 1'b0}, 1'b0);
      do_cmd(OP_STOP, 8'h00, 1'b0);
      if (k == 0) chk("first poll", {7'h00, nk}, 8'h01);
    end while (nk === 1'b1 && ++k < 20);
    chk("poll done", {7'h00, nk}, 8'h00);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #2400000;
    error_cnt++;
    tally_and_finish;
  end

  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_mack = 1'b0;
    strap = 3'h5;
    write_protect = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("idle", {5'h00, bus_if.scl, bus_if.sda, prog_busy}, 8'h06);
    // Top two address bits are sent as ones and must be ignored
    sel(8'hFF, 8'hFF);
    wb(8'h11, 1'b0);
    wb(8'h22, 1'b0);
    do_cmd(OP_STOP, 8'h00, 1'b0);
    poll();
    chk("busy runs", 8'(busy_n), 8'h01);
    sel(8'hFF, 8'hFF);
    sa(1'b1, 1'b0);
    rb(1'b1, 8'h11);
    rb(1'b0, ERASED_BYTE);
    do_cmd(OP_STOP, 8'h00, 1'b0);
    sel(8'hFF, 8'hC0);
    sa(1'b1, 1'b0);
    rb(1'b0, 8'h22);
    do_cmd(OP_STOP, 8'h00, 1'b0);
    $display("wrap test done");
    sel(8'h05, 8'h00);
    for (i = 0; i < 66; i++) wb(8'(i), 1'b0);
    do_cmd(OP_STOP, 8'h00, 1'b0);
    poll();
    sel(8'h05, 8'h00);
    sa(1'b1, 1'b0);
    for (i = 0; i < 4; i++) rb(i < 3, (i < 2) ? 8'(i + 64) : 8'(i));
    do_cmd(OP_STOP, 8'h00, 1'b0);
    sa(1'b1, 1'b0);
    rb(1'b0, 8'h04);
    do_cmd(OP_STOP, 8'h00, 1'b0);
    $display("page test done");
    @(posedge clk);
    write_protect <= 1'b1;
    b0 = busy_n;
    sel(8'h05, 8'h00);
    wb(8'hAA, 1'b1);
    do_cmd(OP_STOP, 8'h00, 1'b0);
    sel(8'h05, 8'h00);
    sa(1'b1, 1'b0);
    rb(1'b0, 8'h40);
    do_cmd(OP_STOP, 8'h00, 1'b0);
    chk("no write cycle", 8'(busy_n - b0), 8'h00);
    write_protect <= 1'b0;
    $display("protect test done");
    for (i = 0; i < 4; i++) begin
      do_cmd(OP_START, 8'h00, 1'b0);
      do_cmd(OP_WRITE, (i < 3) ? {DEV_TYPE, strap ^ (3'h1 << i), 1'b0}
                               : {4'hB, strap, 1'b0}, 1'b0);
      chk("foreign address", {7'h00, nk}, 8'h01);
      do_cmd(OP_STOP, 8'h00, 1'b0);
    end
    @(posedge clk);
    strap <= 3'h2;
    sa(1'b1, 1'b0);
    // Counter still sits after the protect test read of the page start
    rb(1'b0, 8'h41);
    do_cmd(OP_STOP, 8'h00, 1'b0);
    $display("address test done");
    tally_and_finish;
  end
endmodule
